// [src/iac_pkg.sv]
// constants and types shared by both ends of the isa address and command port
// Function
// - device drives seven upper address lines 23..17
// - address, enable, select undefined during reset
// - fast dma cycles leave addresses undefined
// - byte address 19..17 equals upper lines, except io cycles park 19..16 at zero
// - io cycles use only address bits 15..0
// - byte address driven when owner, else input
// - owner asserts upper byte enable for high byte
// - upper byte enable negated during refresh
// - wide slave pulls select from upper lines
// - device pulls select for master pci memory
// - master asserts ownership only after grant ack
// - owner keeps bus; device drives no cycles
// - read strobe: slave drives; write strobe: slave latches
// - device drives strobes only as bus master
// - device drives read strobe during refresh
// - compatible dma strobes only below 16 mbytes
// - fast dma cycles keep both strobes inactive
// - dma grant ack also grants bus to master
package iac_pkg;
  localparam int UA_W  = 7;
  localparam int SA_W  = 20;
  localparam int FA_W  = 32;
  localparam int UA_LO = 17;
  localparam int IO_W  = 16;
  localparam int STROBE_CYC = 4;
  localparam logic [FA_W-1:0] LIMIT_16M = 32'h0100_0000;
  localparam logic [3:0] IO_ZERO = 4'h0;

  typedef enum logic [2:0] {
    IAC_CYC_MEM_RD,
    IAC_CYC_MEM_WR,
    IAC_CYC_IO,
    IAC_CYC_REFRESH,
    IAC_CYC_DMA_COMPAT_RD,
    IAC_CYC_DMA_COMPAT_WR,
    IAC_CYC_DMA_FAST
  } iac_cyc_t;
endpackage : iac_pkg

// [src/iac_bus_if.sv]
// isa address and command wires joining the bridge end and the external master end
`timescale 1ns/10ps
`default_nettype none
interface iac_bus_if;
  logic [6:0]  ua_dev_o, ua_mst_o;
  logic        ua_dev_oe, ua_mst_oe;
  logic [19:0] ba_dev_o, ba_mst_o;
  logic        ba_dev_oe, ba_mst_oe;
  logic        ube_n_dev_o, ube_n_mst_o, ube_dev_oe, ube_mst_oe;
  logic        rd_n_dev_o, rd_n_mst_o, rd_dev_oe, rd_mst_oe;
  logic        wr_n_dev_o, wr_n_mst_o, wr_dev_oe, wr_mst_oe;
  logic        wsel_dev_oe, wsel_slv_oe;
  logic        grant_ack_n;
  logic        owner_n;
  // resolved wire levels; pullups read high when nobody drives
  logic [6:0]  upper_address_lines;
  logic [19:0] byte_address_bus;
  logic        upper_byte_enable_n, memory_read_strobe_n, memory_write_strobe_n;
  logic        wide_memory_select_n;
  assign upper_address_lines   = ua_dev_oe ? ua_dev_o : (ua_mst_oe ? ua_mst_o : '1);
  assign byte_address_bus      = ba_dev_oe ? ba_dev_o : (ba_mst_oe ? ba_mst_o : '1);
  assign upper_byte_enable_n   = ube_dev_oe ? ube_n_dev_o : (ube_mst_oe ? ube_n_mst_o : 1'b1);
  assign memory_read_strobe_n  = rd_dev_oe ? rd_n_dev_o : (rd_mst_oe ? rd_n_mst_o : 1'b1);
  assign memory_write_strobe_n = wr_dev_oe ? wr_n_dev_o : (wr_mst_oe ? wr_n_mst_o : 1'b1);
  assign wide_memory_select_n  = ~(wsel_dev_oe | wsel_slv_oe);

  modport bridge (
    output ua_dev_o, ua_dev_oe, ba_dev_o, ba_dev_oe, ube_n_dev_o, ube_dev_oe,
    output rd_n_dev_o, rd_dev_oe, wr_n_dev_o, wr_dev_oe, wsel_dev_oe, grant_ack_n,
    input  upper_address_lines, byte_address_bus, upper_byte_enable_n,
    input  memory_read_strobe_n, memory_write_strobe_n, wide_memory_select_n, owner_n
  );
  modport master (
    output ua_mst_o, ua_mst_oe, ba_mst_o, ba_mst_oe, ube_n_mst_o, ube_mst_oe,
    output rd_n_mst_o, rd_mst_oe, wr_n_mst_o, wr_mst_oe, owner_n,
    input  wide_memory_select_n, grant_ack_n
  );
endinterface : iac_bus_if
`default_nettype wire

// [src/iac_bridge.sv]
// bridge end: drives address and memory strobes, yields the bus to external masters
`timescale 1ns/10ps
`default_nettype none
module iac_bridge (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // cycle request from the bridge core
  input  wire logic                     cyc_req,
  input  wire iac_pkg::iac_cyc_t        cyc_type,
  input  wire logic [iac_pkg::FA_W-1:0] cyc_addr,
  input  wire logic                     cyc_hi_byte,
  output logic                          cyc_done,
  output logic                          cyc_busy,
  // grant request from an external master
  input  wire logic                     mst_req,
  // master cycle hitting pci-side memory
  input  wire logic                     mst_pci_hit,
  // observed bus, for the core
  output logic                          ext_owned,
  output logic [iac_pkg::SA_W-1:0]      ext_addr,
  output logic                          ext_rd,
  output logic                          ext_wr,
  // isa side
  iac_bus_if.bridge                     bus
);
  import iac_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_CYC, ST_GRANT, ST_EXT} iac_st_t;
  // whole state in one register so reset and update stay in one place
  typedef struct packed {
    iac_st_t          st;
    logic [2:0]       cnt;
    logic [UA_W-1:0]  ua;
    logic [SA_W-1:0]  ba;
    logic             drv;
    logic             ube_n;
    logic             rd_n;
    logic             wr_n;
    logic             wsel;
    logic             ack_n;
    logic             done;
    logic             owned;
    logic             busy;
    logic             soe;
    logic [SA_W-1:0]  xa;
    logic             xrd;
    logic             xwr;
  } iac_br_t;

  iac_br_t s_r, s_nxt;

  function automatic logic below_16m(input logic [FA_W-1:0] a);
    below_16m = (a < LIMIT_16M);
  endfunction : below_16m

  // fast dma leaves the address lines to float
  function automatic logic addr_driven(input iac_cyc_t t);
    addr_driven = (t != IAC_CYC_DMA_FAST);
  endfunction : addr_driven

  function automatic logic [UA_W-1:0] upper_addr(input logic [FA_W-1:0] a);
    upper_addr = a[UA_LO +: UA_W];
  endfunction : upper_addr

  // io slaves decode only the low word, so the top nibble is parked at zero
  function automatic logic [SA_W-1:0] byte_addr(input iac_cyc_t t, input logic [FA_W-1:0] a);
    if (t == IAC_CYC_IO) begin
      byte_addr = {IO_ZERO, a[IO_W-1:0]};
    end else begin
      byte_addr = a[SA_W-1:0];
    end
  endfunction : byte_addr

  function automatic logic ube_level_n(input iac_cyc_t t, input logic hi);
    ube_level_n = ~hi | (t == IAC_CYC_REFRESH);
  endfunction : ube_level_n

  // a compatible dma strobe above 16 mbytes is swallowed rather than aliased low
  function automatic logic rd_wanted(input iac_cyc_t t, input logic [FA_W-1:0] a);
    case (t)
      IAC_CYC_MEM_RD:        rd_wanted = 1'b1;
      IAC_CYC_REFRESH:       rd_wanted = 1'b1;
      IAC_CYC_DMA_COMPAT_RD: rd_wanted = below_16m(a);
      default:               rd_wanted = 1'b0;
    endcase
  endfunction : rd_wanted

  function automatic logic wr_wanted(input iac_cyc_t t, input logic [FA_W-1:0] a);
    case (t)
      IAC_CYC_MEM_WR:        wr_wanted = 1'b1;
      IAC_CYC_DMA_COMPAT_WR: wr_wanted = below_16m(a);
      default:               wr_wanted = 1'b0;
    endcase
  endfunction : wr_wanted

  // select is pulled one clock after the master's command goes low and stays pulled one clock after it rises
  function automatic logic pci_sel(input logic hit, input logic rd_n, input logic wr_n);
    pci_sel = hit & (~rd_n | ~wr_n);
  endfunction : pci_sel

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.wsel = 1'b0;
    // only an external master's cycle is reported, never an echo of our own
    if (s_r.owned) begin
      s_nxt.xa  = bus.byte_address_bus;
      s_nxt.xrd = ~bus.memory_read_strobe_n;
      s_nxt.xwr = ~bus.memory_write_strobe_n;
    end else begin
      s_nxt.xrd = 1'b0;
      s_nxt.xwr = 1'b0;
    end
    case (s_r.st)
      ST_IDLE: begin
        // an external master outranks a core cycle
        if (mst_req) begin
          s_nxt.st    = ST_GRANT;
          s_nxt.ack_n = 1'b0;
        end else if (cyc_req) begin
          s_nxt.st    = ST_CYC;
          s_nxt.cnt   = 3'(STROBE_CYC - 1);
          s_nxt.drv   = addr_driven(cyc_type);
          s_nxt.ua    = upper_addr(cyc_addr);
          s_nxt.ba    = byte_addr(cyc_type, cyc_addr);
          s_nxt.ube_n = ube_level_n(cyc_type, cyc_hi_byte);
          s_nxt.rd_n  = ~rd_wanted(cyc_type, cyc_addr);
          s_nxt.wr_n  = ~wr_wanted(cyc_type, cyc_addr);
        end
      end
      // strobes and address drop together at the end of the cycle
      ST_CYC: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.st   = ST_IDLE;
          s_nxt.rd_n = 1'b1;
          s_nxt.wr_n = 1'b1;
          s_nxt.drv  = 1'b0;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      ST_GRANT: begin
        // master may only take the bus after seeing the ack
        if (!bus.owner_n) begin
          s_nxt.st    = ST_EXT;
          s_nxt.owned = 1'b1;
        end else if (!mst_req) begin
          s_nxt.st    = ST_IDLE;
          s_nxt.ack_n = 1'b1;
        end
      end
      ST_EXT: begin
        s_nxt.wsel = pci_sel(mst_pci_hit, bus.memory_read_strobe_n,
                             bus.memory_write_strobe_n);
        // ownership ends only on the master's own release
        if (bus.owner_n) begin
          s_nxt.st    = ST_IDLE;
          s_nxt.owned = 1'b0;
          s_nxt.ack_n = 1'b1;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // registered so the enables and busy leave the module straight from flops
    s_nxt.busy = (s_nxt.st != ST_IDLE);
    s_nxt.soe  = (s_nxt.st == ST_CYC);
  end

  // reset leaves address lines undriven, so they read high from the pullups
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r       <= '0;
      s_r.st    <= ST_IDLE;
      s_r.ube_n <= 1'b1;
      s_r.rd_n  <= 1'b1;
      s_r.wr_n  <= 1'b1;
      s_r.ack_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // address, byte enable, select and grant toward the isa lines
  assign bus.ua_dev_o    = s_r.ua;
  assign bus.ba_dev_o    = s_r.ba;
  assign bus.ua_dev_oe   = s_r.drv;
  assign bus.ba_dev_oe   = s_r.drv;
  assign bus.ube_n_dev_o = s_r.ube_n;
  assign bus.ube_dev_oe  = s_r.drv;
  assign bus.wsel_dev_oe = s_r.wsel;
  assign bus.grant_ack_n = s_r.ack_n;

  // strobes go back to the pullups outside the bridge's own cycles
  assign bus.rd_n_dev_o  = s_r.rd_n;
  assign bus.wr_n_dev_o  = s_r.wr_n;
  assign bus.rd_dev_oe   = s_r.soe;
  assign bus.wr_dev_oe   = s_r.soe;

  // core side
  assign cyc_done  = s_r.done;
  assign cyc_busy  = s_r.busy;
  assign ext_owned = s_r.owned;
  assign ext_addr  = s_r.xa;
  assign ext_rd    = s_r.xrd;
  assign ext_wr    = s_r.xwr;
endmodule : iac_bridge
`default_nettype wire

// [src/iac_ext_master.sv]
// external master end: requests the bus, takes it after the grant ack, runs memory cycles
`timescale 1ns/10ps
`default_nettype none
module iac_ext_master (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // user requests
  input  wire logic                     usr_req,
  input  wire logic                     usr_write,
  input  wire logic [23:0]              usr_addr,
  input  wire logic                     usr_hi_byte,
  output logic                          usr_done,
  output logic                          usr_wide,
  // grant request to the bridge
  output logic                          bus_req,
  // isa side
  iac_bus_if.master                     bus
);
  import iac_pkg::*;

  typedef enum logic [1:0] {MS_IDLE, MS_WAIT, MS_OWN, MS_STB} iac_ms_t;
  typedef struct packed {
    iac_ms_t          st;
    logic [2:0]       cnt;
    logic             req, own_n, drv, rd_n, wr_n, ube_n, done, wide;
    logic [UA_W-1:0]  ua;
    logic [SA_W-1:0]  ba;
  } iac_mst_t;

  iac_mst_t m_r, m_nxt;

  always_comb begin
    m_nxt      = m_r;
    m_nxt.done = 1'b0;
    case (m_r.st)
      MS_IDLE: if (usr_req) begin
        m_nxt.st  = MS_WAIT;
        m_nxt.req = 1'b1;
      end
      MS_WAIT: if (!bus.grant_ack_n) begin
        m_nxt.st    = MS_OWN;
        m_nxt.own_n = 1'b0;
        m_nxt.drv   = 1'b1;
        m_nxt.ua    = usr_addr[UA_LO +: UA_W];
        m_nxt.ba    = usr_addr[SA_W-1:0];
        m_nxt.ube_n = ~usr_hi_byte;
      end
      MS_OWN: begin
        m_nxt.st   = MS_STB;
        m_nxt.cnt  = 3'(STROBE_CYC - 1);
        m_nxt.rd_n = usr_write;
        m_nxt.wr_n = ~usr_write;
      end
      MS_STB: begin
        m_nxt.wide = ~bus.wide_memory_select_n;
        if (m_r.cnt == 3'h0) begin
          m_nxt.st   = MS_IDLE;
          m_nxt.rd_n = 1'b1;
          m_nxt.wr_n = 1'b1;
          m_nxt.drv  = 1'b0;
          m_nxt.own_n = 1'b1;
          m_nxt.req  = 1'b0;
          m_nxt.done = 1'b1;
        end else begin
          m_nxt.cnt = m_r.cnt - 3'h1;
        end
      end
      default: m_nxt.st = MS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      m_r       <= '0;
      m_r.st    <= MS_IDLE;
      m_r.rd_n  <= 1'b1;
      m_r.wr_n  <= 1'b1;
      m_r.ube_n <= 1'b1;
      m_r.own_n <= 1'b1;
    end else begin
      m_r <= m_nxt;
    end
  end

  assign bus.owner_n     = m_r.own_n;
  assign bus.ua_mst_o    = m_r.ua;
  assign bus.ba_mst_o    = m_r.ba;
  assign bus.ua_mst_oe   = m_r.drv;
  assign bus.ba_mst_oe   = m_r.drv;
  assign bus.ube_n_mst_o = m_r.ube_n;
  assign bus.ube_mst_oe  = m_r.drv;
  assign bus.rd_n_mst_o  = m_r.rd_n;
  assign bus.wr_n_mst_o  = m_r.wr_n;
  assign bus.rd_mst_oe   = m_r.drv;
  assign bus.wr_mst_oe   = m_r.drv;
  assign bus_req  = m_r.req;
  assign usr_done = m_r.done;
  assign usr_wide = m_r.wide;
endmodule : iac_ext_master
`default_nettype wire

// [verification/iac_asserts.sv]
// checker on the isa address and command wires between both ends
`timescale 1ns/10ps
`default_nettype none
module iac_asserts (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // resolved wires
  input wire logic [6:0]  upper_address_lines,
  input wire logic [19:0] byte_address_bus,
  input wire logic        memory_read_strobe_n,
  input wire logic        memory_write_strobe_n,
  // bridge enables and handshake
  input wire logic        ua_dev_oe,
  input wire logic        ba_dev_oe,
  input wire logic        rd_dev_oe,
  input wire logic        wr_dev_oe,
  input wire logic        wsel_dev_oe,
  input wire logic        grant_ack_n,
  input wire logic        owner_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence rd_pulse;
    !memory_read_strobe_n [*4] ##1 memory_read_strobe_n;
  endsequence
  sequence wr_pulse;
    !memory_write_strobe_n [*4] ##1 memory_write_strobe_n;
  endsequence
  a_addr_match: assert property (
    (!memory_read_strobe_n || !memory_write_strobe_n) && ua_dev_oe && ba_dev_oe
    |-> byte_address_bus[19:17] == upper_address_lines[2:0]) else $error("address mismatch");
  a_rd_len: assert property (
    $fell(memory_read_strobe_n) && rd_dev_oe |-> rd_pulse) else $error("read strobe length");
  a_wr_len: assert property (
    $fell(memory_write_strobe_n) && wr_dev_oe |-> wr_pulse) else $error("write strobe length");
  a_yield_bus: assert property (
    !owner_n |-> !ba_dev_oe && !rd_dev_oe && !wr_dev_oe) else $error("bridge drives owned bus");
  a_own_after_ack: assert property (
    $fell(owner_n) |-> $past(grant_ack_n) == 1'b0) else $error("ownership before ack");
  a_ack_holds: assert property (
    !grant_ack_n && !owner_n |=> !grant_ack_n) else $error("ack dropped while owned");
  a_ack_release: assert property (
    $rose(owner_n) |=> grant_ack_n) else $error("ack not released");
  a_sel_master: assert property (
    wsel_dev_oe |-> !owner_n || $past(owner_n, 2) == 1'b0) else $error("select outside master");
  a_cmd_excl: assert property (
    memory_read_strobe_n || memory_write_strobe_n) else $error("both strobes low");
endmodule : iac_asserts
`default_nettype wire

// [verification/test_isa_address_command_port.sv]
// self-checking bench joining the bridge end and the external master end
`timescale 1ns/10ps
`default_nettype none
module test_isa_address_command_port;
  import iac_pkg::*;
  logic        clk_sys, resetn, cyc_req, cyc_hi_byte, cyc_done, cyc_busy;
  logic        mst_req, mst_pci_hit, ext_owned, ext_rd, ext_wr;
  logic        usr_req, usr_write, usr_hi_byte, usr_done, usr_wide;
  iac_cyc_t    cyc_type;
  logic [31:0] cyc_addr;
  logic [19:0] ext_addr;
  logic [23:0] usr_addr;
  int          error_cnt, comparisons, n;
  // a wide memory slave sits in this 128 kbyte block and decodes the upper lines alone
  localparam logic [6:0] SLV_UA = 7'h05;

  iac_bus_if bus ();
  iac_bridge u_iac_bridge (.clk_sys(clk_sys), .resetn(resetn), .cyc_req(cyc_req),
    .cyc_type(cyc_type), .cyc_addr(cyc_addr), .cyc_hi_byte(cyc_hi_byte),
    .cyc_done(cyc_done), .cyc_busy(cyc_busy), .mst_req(mst_req),
    .mst_pci_hit(mst_pci_hit), .ext_owned(ext_owned), .ext_addr(ext_addr),
    .ext_rd(ext_rd), .ext_wr(ext_wr), .bus(bus));
  // the master's request feeds the bridge directly so arbitration is exercised
  iac_ext_master u_iac_ext_master (.clk_sys(clk_sys), .resetn(resetn), .usr_req(usr_req),
    .usr_write(usr_write), .usr_addr(usr_addr), .usr_hi_byte(usr_hi_byte),
    .usr_done(usr_done), .usr_wide(usr_wide), .bus_req(mst_req), .bus(bus));
  iac_asserts u_iac_asserts (.clk_sys(clk_sys), .resetn(resetn),
    .upper_address_lines(bus.upper_address_lines), .byte_address_bus(bus.byte_address_bus),
    .memory_read_strobe_n(bus.memory_read_strobe_n),
    .memory_write_strobe_n(bus.memory_write_strobe_n), .ua_dev_oe(bus.ua_dev_oe),
    .ba_dev_oe(bus.ba_dev_oe), .rd_dev_oe(bus.rd_dev_oe), .wr_dev_oe(bus.wr_dev_oe),
    .wsel_dev_oe(bus.wsel_dev_oe), .grant_ack_n(bus.grant_ack_n), .owner_n(bus.owner_n));
  assign bus.wsel_slv_oe = (bus.upper_address_lines == SLV_UA);

  function automatic logic exp_rd(input iac_cyc_t t, input logic [31:0] a);
    return t == IAC_CYC_MEM_RD || t == IAC_CYC_REFRESH ||
           (t == IAC_CYC_DMA_COMPAT_RD && a < LIMIT_16M);
  endfunction : exp_rd
  function automatic logic exp_wr(input iac_cyc_t t, input logic [31:0] a);
    return t == IAC_CYC_MEM_WR || (t == IAC_CYC_DMA_COMPAT_WR && a < LIMIT_16M);
  endfunction : exp_wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // bounded wait on either completion pulse
  task automatic wait_done(input logic m);
    n = 0;
    while (!(m ? usr_done : cyc_done) && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n < 40, 1);
    @(negedge clk_sys);
  endtask : wait_done
  task automatic run_cyc(input iac_cyc_t t, input logic [31:0] a, input logic h);
    cyc_type = t;
    cyc_addr = a;
    cyc_hi_byte = h;
    cyc_req = 1'b1;
    @(negedge clk_sys);
    cyc_req = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(bus.memory_read_strobe_n, !exp_rd(t, a));
    chk(bus.memory_write_strobe_n, !exp_wr(t, a));
    if (t == IAC_CYC_REFRESH)
      chk(bus.upper_byte_enable_n, 1);
    else if (t == IAC_CYC_DMA_FAST)
      chk(bus.ba_dev_oe, 0);
    else begin
      chk(bus.upper_byte_enable_n, !h);
      chk(bus.byte_address_bus, t == IAC_CYC_IO ? {IO_ZERO, a[15:0]} : a[19:0]);
      if (t != IAC_CYC_IO)
        chk(bus.upper_address_lines, a[23:17]);
    end
    chk(cyc_busy, 1);
    wait_done(1'b0);
    chk(cyc_busy, 0);
  endtask : run_cyc

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #(50 * 4000);
    error_cnt++;
    results();
  end
  initial begin
    {resetn, cyc_req, cyc_hi_byte, mst_pci_hit, usr_req, usr_write, usr_hi_byte} = '0;
    cyc_type = IAC_CYC_MEM_RD;
    cyc_addr = '0;
    usr_addr = '0;
    void'($urandom(32'h72d3459f));
    repeat (12) @(negedge clk_sys);
    chk({bus.ua_dev_oe, bus.ba_dev_oe, bus.ube_dev_oe, bus.rd_dev_oe}, 0);
    resetn = 1'b1;
    // both sides of the 16 mbyte boundary
    run_cyc(IAC_CYC_DMA_COMPAT_RD, 32'h00ff_ffff, 1'b0);
    run_cyc(IAC_CYC_DMA_COMPAT_WR, LIMIT_16M, 1'b1);
    for (int i = 0; i < 42; i++)
      run_cyc(iac_cyc_t'(i % 7), $urandom & 32'h01ff_ffff, 1'($urandom));
    for (int i = 0; i < 6; i++) begin
      usr_addr = (i == 0) ? {SLV_UA, 17'($urandom)} : 24'($urandom);
      usr_write = 1'($urandom);
      usr_hi_byte = 1'($urandom);
      mst_pci_hit = (i == 0) ? 1'b0 : ((i == 1) ? 1'b1 : 1'($urandom));
      usr_req = 1'b1;
      @(negedge clk_sys);
      usr_req = 1'b0;
      n = 0;
      while (bus.memory_read_strobe_n && bus.memory_write_strobe_n && n < 40) begin
        @(negedge clk_sys);
        n++;
      end
      repeat (2) @(negedge clk_sys);
      chk(ext_owned, 1);
      chk(ext_addr, usr_addr[19:0]);
      chk({ext_rd, ext_wr}, {!usr_write, usr_write});
      wait_done(1'b1);
      chk(usr_wide, mst_pci_hit | (usr_addr[23:17] == SLV_UA));
      repeat (4) @(negedge clk_sys);
    end
    // bus handed back: bridge must run cycles again
    run_cyc(IAC_CYC_MEM_RD, 32'h0012_3456, 1'b1);
    results();
  end
endmodule : test_isa_address_command_port
`default_nettype wire
